// *** rtl/drbt_ctrl.sv ***
`timescale 1ns/1ps
module drbt_ctrl
  import drbt_pkg::*;
#(
  parameter int CK_DIV = CK_DIV_DEF,
  parameter int AL     = AL_DEF,
  parameter int T_RAS  = T_RAS_DEF,
  parameter int T_RP   = T_RP_DEF,
  parameter int T_RC   = T_RC_DEF,
  parameter int DW     = DW_DEF,
  parameter int NB     = NB_DEF
) (
  input  logic               clock,
  input  logic               rst_n,
  drbt_if.ctrl               link,
  input  logic [1:0]         burst_mode,
  input  logic               req_valid,
  output logic               req_ready,
  input  drbt_cmd_e          req_cmd,
  input  logic [BA_W-1:0]    req_bank,
  input  logic [ADDR_W-1:0]  req_addr,
  input  logic               req_bl8,
  output logic               rd_valid,
  output logic [2*DW-1:0]    rd_data
);

  // ***********************************************************
  // derived timing
  // ***********************************************************
  localparam int HALF   = CK_DIV / 2;
  localparam int DIV_W  = $clog2(CK_DIV);
  localparam int CKP_PS = CK_DIV * CLK_PERIOD_PS;
  localparam int RTP_NS = (RTP_MIN_PS + CKP_PS - 1) / CKP_PS;
  localparam int RTP_CK = (RTP_NS > RTP_MIN_CK) ? RTP_NS : RTP_MIN_CK;

  function automatic logic [TMR_W-1:0] dec(input logic [TMR_W-1:0] v);
    dec = (v == '0) ? '0 : v - TMR_W'(1);
  endfunction : dec

  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  div_next;
  logic              slot;
  logic [2:0]        lrst_reg;
  logic              pend_reg;
  logic              pend_next;
  drbt_cmd_e         pcmd_reg;
  logic [BA_W-1:0]   pba_reg;
  logic [ADDR_W-1:0] paddr_reg;
  logic              pbl8_reg;
  logic              bsel;
  logic              eff8;
  logic              legal;
  logic              issue;
  logic [ADDR_W-1:0] addr_out;
  logic [TMR_W-1:0]  ccd_reg;
  logic [TMR_W-1:0]  rtw_reg;
  logic [TMR_W-1:0]  ras_reg [NB];
  logic [TMR_W-1:0]  rc_reg  [NB];
  logic [TMR_W-1:0]  rp_reg  [NB];
  logic [TMR_W-1:0]  rtp_reg [NB];
  logic [2*DW-1:0]   s1_dq;
  logic [2*DW-1:0]   s2_dq;
  logic              s1_oe;
  logic              s2_oe;

  // ***********************************************************
  // link clock divider and link reset
  // ***********************************************************
  always_comb begin
    div_next = (div_reg == DIV_W'(CK_DIV - 1)) ? '0 : div_reg + DIV_W'(1);
    slot     = (div_reg == DIV_W'(HALF - 1));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_reg <= '0;
      link.ck <= 1'b0;
    end else begin
      div_reg <= div_next;
      link.ck <= (div_next < DIV_W'(HALF));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lrst_reg        <= '0;
      link.rst_link_n <= 1'b0;
    end else if (slot) begin
      if (lrst_reg != 3'(LINK_RST_CK)) begin
        lrst_reg <= lrst_reg + 3'h1;
      end else begin
        link.rst_link_n <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // request holding
  // ***********************************************************
  always_comb begin
    bsel = (burst_mode == BURST_OTF) ? pbl8_reg : (burst_mode == BURST_FIXED8);
    eff8 = burst_is8(burst_mode, bsel);
    addr_out = paddr_reg;
    addr_out[BSEL_BIT] = bsel;
    legal = 1'b1;
    unique case (pcmd_reg)
      CMD_NOP: legal = 1'b1;
      CMD_RD:  legal = (ccd_reg == '0);
      CMD_WR:  legal = (ccd_reg == '0) && (rtw_reg == '0);
      CMD_PRE: legal = (ras_reg[pba_reg] == '0) && (rtp_reg[pba_reg] == '0);
      CMD_ACT: legal = (rp_reg[pba_reg] == '0) && (rc_reg[pba_reg] == '0);
    endcase
    issue = slot && pend_reg && legal && link.rst_link_n;
    if (req_valid && req_ready) begin
      pend_next = 1'b1;
    end else if (issue) begin
      pend_next = 1'b0;
    end else begin
      pend_next = pend_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_reg  <= 1'b0;
      req_ready <= 1'b0;
      pcmd_reg  <= CMD_NOP;
      pba_reg   <= '0;
      paddr_reg <= '0;
      pbl8_reg  <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      req_ready <= !pend_next;
      if (req_valid && req_ready) begin
        pcmd_reg  <= req_cmd;
        pba_reg   <= req_bank;
        paddr_reg <= req_addr;
        pbl8_reg  <= req_bl8;
      end
    end
  end

  // ***********************************************************
  // command drive, changes as the link clock falls
  // ***********************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.cmd  <= CMD_NOP;
      link.ba   <= '0;
      link.addr <= '0;
    end else if (slot) begin
      link.cmd <= issue ? pcmd_reg : CMD_NOP;
      if (issue) begin
        link.ba   <= pba_reg;
        link.addr <= addr_out;
      end
    end
  end

  // ***********************************************************
  // spacing timers in link clock cycles
  // ***********************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ccd_reg <= '0;
      rtw_reg <= '0;
    end else if (slot) begin
      if (issue && pcmd_reg == CMD_RD) begin
        ccd_reg <= TMR_W'(CCD_CK - 1);
        rtw_reg <= eff8 ? TMR_W'(RTW_BL8_CK - 1) : TMR_W'(RTW_BC4_CK - 1);
      end else begin
        ccd_reg <= (issue && pcmd_reg == CMD_WR) ? TMR_W'(CCD_CK - 1) : dec(ccd_reg);
        rtw_reg <= dec(rtw_reg);
      end
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hit;
    assign hit = issue && (pba_reg == BA_W'(b));
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        ras_reg[b] <= '0;
        rc_reg[b]  <= '0;
        rp_reg[b]  <= '0;
        rtp_reg[b] <= '0;
      end else if (slot) begin
        ras_reg[b] <= (hit && pcmd_reg == CMD_ACT) ? TMR_W'(T_RAS - 1) : dec(ras_reg[b]);
        rc_reg[b]  <= (hit && pcmd_reg == CMD_ACT) ? TMR_W'(T_RC - 1) : dec(rc_reg[b]);
        rp_reg[b]  <= (hit && pcmd_reg == CMD_PRE) ? TMR_W'(T_RP - 1) : dec(rp_reg[b]);
        rtp_reg[b] <= (hit && pcmd_reg == CMD_RD) ? TMR_W'(AL + RTP_CK - 1) : dec(rtp_reg[b]);
      end
    end
  end

  // ***********************************************************
  // read data return
  // ***********************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_dq <= '0;
      s2_dq <= '0;
      s1_oe <= 1'b0;
      s2_oe <= 1'b0;
    end else begin
      s1_dq <= link.dq;
      s2_dq <= s1_dq;
      s1_oe <= link.dq_oe;
      s2_oe <= s1_oe;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= (div_reg == DIV_W'(SMP_PH)) && s2_oe;
      if ((div_reg == DIV_W'(SMP_PH)) && s2_oe) begin
        rd_data <= s2_dq;
      end
    end
  end

endmodule : drbt_ctrl

// *** rtl/drbt_pkg.sv ***
package drbt_pkg;

  // ***********************************************************
  // link commands and field layout
  // ***********************************************************
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} drbt_cmd_e;

  localparam int         DW_DEF       = 16;
  localparam int         ADDR_W       = 14;
  localparam int         BA_W         = 3;
  localparam int         NB_DEF       = 8;
  localparam int         COL_W        = 10;
  localparam int         BSEL_BIT     = 12;
  localparam int         DEPTH_DEF    = 64;
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF    = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;

  // ***********************************************************
  // latencies and spacings in link clock cycles, or in picoseconds where so named
  // ***********************************************************
  localparam int AL_DEF      = 0;
  localparam int CL_DEF      = 5;
  localparam int PRE_LEAD_CK = 1;
  localparam int BL8_DATA_CK = 4;
  localparam int BC4_DATA_CK = 2;
  localparam int CCD_CK      = 4;
  localparam int RTW_BL8_CK  = 6;
  localparam int RTW_BC4_CK  = 4;
  localparam int RTP_MIN_CK  = 4;
  localparam int RTP_MIN_PS  = 7500;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CK_DIV_DEF  = 4;
  localparam int SMP_PH      = 2;
  localparam int T_RAS_DEF   = 15;
  localparam int T_RP_DEF    = 5;
  localparam int T_RC_DEF    = 20;
  localparam int LINK_RST_CK = 4;
  localparam int TMR_W       = 8;

  // ***********************************************************
  // burst length decode
  // ***********************************************************
  function automatic logic burst_is8(input logic [1:0] mode, input logic sel);
    burst_is8 = (mode == BURST_FIXED8) || ((mode == BURST_OTF) && sel);
  endfunction : burst_is8

endpackage : drbt_pkg

// *** rtl/drbt_if.sv ***
`timescale 1ns/1ps
interface drbt_if
  import drbt_pkg::*;
#(
  parameter int DW = DW_DEF
);
  logic              ck;
  logic              rst_link_n;
  drbt_cmd_e         cmd;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic [2*DW-1:0]   dq;
  logic              dq_oe;
  logic              dqs;
  logic              dqs_oe;

  modport dram (
    input  ck,
    input  rst_link_n,
    input  cmd,
    input  ba,
    input  addr,
    output dq,
    output dq_oe,
    output dqs,
    output dqs_oe
  );

  modport ctrl (
    output ck,
    output rst_link_n,
    output cmd,
    output ba,
    output addr,
    input  dq,
    input  dq_oe,
    input  dqs,
    input  dqs_oe
  );
endinterface : drbt_if

// *** rtl/drbt_dram.sv ***
`timescale 1ns/1ps
// Function
// - strobe driven from read latency minus one
// - eight-beat burst releases strobe, data at plus four
// - data release point also at plus two
// - on-the-fly mode: burst select high eight-beat, low chopped; fixed modes ignore it
// - eight-beat reads four apart stream without gap
// - eight-beat reads five apart hold strobe low between
// - read-to-write spacing six or four clocks
// - precharge waits additive latency plus read-to-precharge
// - read-to-precharge is max four clocks, 7.5 ns
// - precharge also waits activate-to-precharge minimum
// - activate waits precharge period and row cycle
// - burst select bit never a column bit
module drbt_dram
  import drbt_pkg::*;
#(
  parameter int AL    = AL_DEF,
  parameter int CL    = CL_DEF,
  parameter int DW    = DW_DEF,
  parameter int NB    = NB_DEF,
  parameter int DEPTH = DEPTH_DEF
) (
  drbt_if.dram                        link,
  input  logic [1:0]                  burst_mode,
  input  logic                        load_en,
  input  logic [$clog2(DEPTH)-1:0]    load_addr,
  input  logic [DW-1:0]               load_data,
  input  logic                        err_clr,
  output logic                        rd_seen,
  output logic                        burst8_seen,
  output logic                        closed_err
);

  // ***********************************************************
  // pipeline geometry
  // ***********************************************************
  localparam int RL     = AL + CL;
  localparam int PIPE_N = RL + BL8_DATA_CK - 1;
  localparam int PRE_J  = RL - PRE_LEAD_CK - 1;
  localparam int DAT_J  = RL - 1;
  localparam int AW     = $clog2(DEPTH);

  logic            take_rd;
  logic            take_act;
  logic            take_pre;
  logic            is8;
  logic [2:0]      span_ck;
  logic [AW-1:0]   col_idx;
  logic [AW-1:0]   adr_hi;
  logic            bank_open;
  logic            drv_reg [PIPE_N];
  logic            dat_reg [PIPE_N];
  logic [AW-1:0]   adr_reg [PIPE_N];
  logic [DW-1:0]   mem_reg [DEPTH];
  logic [NB-1:0]   open_reg;
  logic [1:0]      bm_meta_reg;
  logic [1:0]      bm_sync_reg;

  // ***********************************************************
  // mode setting crosses in from the request clock
  // ***********************************************************
  // level setting, only changed while the link is idle
  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      bm_meta_reg <= BURST_FIXED8;
      bm_sync_reg <= BURST_FIXED8;
    end else begin
      bm_meta_reg <= burst_mode;
      bm_sync_reg <= bm_meta_reg;
    end
  end

  // ***********************************************************
  // command decode
  // ***********************************************************
  always_comb begin
    take_rd   = (link.cmd == CMD_RD);
    take_act  = (link.cmd == CMD_ACT);
    take_pre  = (link.cmd == CMD_PRE);
    is8       = burst_is8(bm_sync_reg, link.addr[BSEL_BIT]);
    span_ck   = is8 ? 3'(BL8_DATA_CK) : 3'(BC4_DATA_CK);
    col_idx   = link.addr[AW-1:0];
    adr_hi    = adr_reg[0] + AW'(1);
    bank_open = open_reg[link.ba];
  end

  // ***********************************************************
  // read schedule: entry i leaves the pipe i+1 cycles later
  // ***********************************************************
  for (genvar i = 0; i < PIPE_N; i++) begin : g_pipe
    logic          shf_drv;
    logic          shf_dat;
    logic [AW-1:0] shf_adr;
    logic          in_win;
    logic          in_dat;

    if (i == PIPE_N - 1) begin : g_top
      assign shf_drv = 1'b0;
      assign shf_dat = 1'b0;
      assign shf_adr = '0;
    end else begin : g_mid
      assign shf_drv = drv_reg[i+1];
      assign shf_dat = dat_reg[i+1];
      assign shf_adr = adr_reg[i+1];
    end

    // strobe window from preamble to last data cycle
    assign in_win = take_rd && (i >= PRE_J) && (i < DAT_J + int'(span_ck));
    assign in_dat = in_win && (i >= DAT_J);

    always_ff @(posedge link.ck) begin
      if (!link.rst_link_n) begin
        drv_reg[i] <= 1'b0;
        dat_reg[i] <= 1'b0;
        adr_reg[i] <= '0;
      end else begin
        // a new preamble merges with an older burst tail
        drv_reg[i] <= shf_drv | in_win;
        dat_reg[i] <= shf_dat | in_dat;
        if (in_dat) begin
          adr_reg[i] <= col_idx + AW'(2 * (i - DAT_J));
        end else begin
          adr_reg[i] <= shf_adr;
        end
      end
    end
  end

  // ***********************************************************
  // link outputs
  // ***********************************************************
  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      link.dqs_oe <= 1'b0;
      link.dqs    <= 1'b0;
    end else begin
      // driven low in preamble and in a one-cycle gap
      link.dqs_oe <= drv_reg[0];
      link.dqs    <= dat_reg[0];
    end
  end

  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      link.dq_oe <= 1'b0;
      link.dq    <= '0;
    end else begin
      link.dq_oe <= dat_reg[0];
      if (dat_reg[0]) begin
        link.dq <= {mem_reg[adr_hi], mem_reg[adr_reg[0]]};
      end else begin
        link.dq <= '0;
      end
    end
  end

  // ***********************************************************
  // array contents
  // ***********************************************************
  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= '0;
      end
    end else if (load_en) begin
      mem_reg[load_addr] <= load_data;
    end
  end

  // ***********************************************************
  // open bank tracking
  // ***********************************************************
  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      open_reg <= '0;
    end else if (take_act) begin
      open_reg[link.ba] <= 1'b1;
    end else if (take_pre) begin
      open_reg[link.ba] <= 1'b0;
    end
  end

  // ***********************************************************
  // user side status
  // ***********************************************************
  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      rd_seen     <= 1'b0;
      burst8_seen <= 1'b0;
    end else begin
      rd_seen <= take_rd;
      if (take_rd) begin
        burst8_seen <= is8;
      end
    end
  end

  always_ff @(posedge link.ck) begin
    if (!link.rst_link_n) begin
      closed_err <= 1'b0;
    end else if (take_rd && !bank_open) begin
      closed_err <= 1'b1;
    end else if (err_clr) begin
      closed_err <= 1'b0;
    end
  end

endmodule : drbt_dram

// *** verif/drbt_chk.sv ***
`timescale 1ns/1ps
module drbt_chk
  import drbt_pkg::*;
#(
  parameter int AL = AL_DEF,
  parameter int CL = CL_DEF,
  parameter int DW = DW_DEF
) (
  input logic              ck,
  input logic              rst_link_n,
  input drbt_cmd_e         cmd,
  input logic [BA_W-1:0]   ba,
  input logic [ADDR_W-1:0] addr,
  input logic [2*DW-1:0]   dq,
  input logic              dq_oe,
  input logic              dqs,
  input logic              dqs_oe
);
  localparam int RL  = AL + CL;
  localparam int RL1 = RL - 1;

  wire           rd  = (cmd == CMD_RD);
  wire           b8  = addr[BSEL_BIT];
  wire [BA_W:0]  rdb = {rd, ba};
  wire [BA_W:0]  prb = {cmd == CMD_PRE, ba};
  wire [BA_W:0]  acb = {cmd == CMD_ACT, ba};

  // ********
  // link timing, sampled mid-cycle on the falling link clock
  // ********
  default clocking cb @(negedge ck); endclocking
  default disable iff (!rst_link_n);

  chk_strobe_start: assert property (rd |-> ##RL1 dqs_oe)
    else $error("strobe not driven before first data");
  chk_preamble_low: assert property ($rose(dqs_oe) |-> !dqs && !dq_oe ##1 dqs && dq_oe)
    else $error("preamble not one low strobe cycle");
  chk_first_data: assert property (rd |-> ##RL dq_oe && dqs)
    else $error("data not driven at read latency");
  chk_data_cause: assert property ($rose(dq_oe) |-> $past(cmd, RL) == CMD_RD)
    else $error("data driven without a read");
  chk_eight_beats: assert property (rd && b8 |-> ##RL dq_oe [*4])
    else $error("eight-beat burst shorter than four cycles");
  chk_eight_release: assert property (rd && b8 ##1 !rd [*5] |-> ##RL1 !dq_oe && !dqs_oe)
    else $error("eight-beat burst not released");
  chk_chop_release: assert property (rd && !b8 |-> ##RL dq_oe [*2] ##1 !dq_oe && !dqs_oe)
    else $error("chopped burst not released after two cycles");
  chk_stream_gapless: assert property (rd && b8 ##4 rd |-> ##RL dq_oe && $past(dq_oe) && dqs)
    else $error("gap between streamed bursts");
  chk_gap_strobe: assert property (rd && b8 ##5 rd |-> ##RL1 dqs_oe && !dqs && !dq_oe)
    else $error("strobe not held low in idle cycle");
  chk_rd_to_wr: assert property (cmd == CMD_WR |->
      !($past(cmd, 4) == CMD_RD && $past(b8, 4)) && !($past(cmd, 5) == CMD_RD && $past(b8, 5)))
    else $error("write too soon after eight-beat read");
  chk_rd_to_pre: assert property (cmd == CMD_PRE |-> $past(rdb, 1) != {1'b1, ba}
      && $past(rdb, 2) != {1'b1, ba} && $past(rdb, 3) != {1'b1, ba})
    else $error("precharge too soon after read");
  // precharge period of three link cycles as set by the bench
  chk_pre_to_act: assert property (cmd == CMD_ACT |->
      $past(prb, 1) != {1'b1, ba} && $past(prb, 2) != {1'b1, ba})
    else $error("activate too soon after precharge");
  // activate-to-precharge minimum of four link cycles as set by the bench
  chk_act_to_pre: assert property (cmd == CMD_PRE |->
      $past(acb, 1) != {1'b1, ba} && $past(acb, 2) != {1'b1, ba}
      && $past(acb, 3) != {1'b1, ba})
    else $error("precharge too soon after activate");

  cov_stream: cover property (rd && b8 ##4 rd);
  cov_gap: cover property (rd && b8 ##5 rd);
  cov_chop: cover property (rd && !b8);
  cov_reopen: cover property (cmd == CMD_ACT && $past(prb, 3) == {1'b1, ba});
endmodule : drbt_chk

// *** verif/drbt_tb.sv ***
`timescale 1ns/1ps
module dram_read_burst_timing_tb
  import drbt_pkg::*;
;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic [1:0]          burst_mode = BURST_FIXED8;
  logic                req_valid = 1'b0;
  logic                req_ready;
  drbt_cmd_e           req_cmd = CMD_NOP;
  logic [BA_W-1:0]     req_bank = '0;
  logic [ADDR_W-1:0]   req_addr = '0;
  logic                req_bl8 = 1'b0;
  logic                rd_valid;
  logic [2*DW_DEF-1:0] rd_data;
  logic                load_en = 1'b0;
  logic [5:0]          load_addr = '0;
  logic [DW_DEF-1:0]   load_data = '0;
  logic                err_clr = 1'b0;
  logic                rd_seen;
  logic                burst8_seen;
  logic                closed_err;
  logic                last8 = 1'b0;
  logic [DW_DEF-1:0]   mem [64];
  logic [31:0]         exp_q [$];
  int                  n_mismatch = 0;
  int                  n_compared = 0;
  int                  n_beats = 0;
  int                  exp_beats = 0;
  int                  n_rd = 0;
  int                  n_seen = 0;
  integer              seed = 32'h9fb834b1;

  drbt_if lnk ();
  drbt_ctrl #(.T_RAS(4), .T_RP(3), .T_RC(6)) u_drbt_ctrl (
    .clock(clock), .rst_n(rst_n), .link(lnk), .burst_mode(burst_mode),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_bl8(req_bl8),
    .rd_valid(rd_valid), .rd_data(rd_data));
  drbt_dram u_drbt_dram (
    .link(lnk), .burst_mode(burst_mode), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .err_clr(err_clr), .rd_seen(rd_seen),
    .burst8_seen(burst8_seen), .closed_err(closed_err));
  drbt_chk u_drbt_chk (
    .ck(lnk.ck), .rst_link_n(lnk.rst_link_n), .cmd(lnk.cmd), .ba(lnk.ba),
    .addr(lnk.addr), .dq(lnk.dq), .dq_oe(lnk.dq_oe), .dqs(lnk.dqs), .dqs_oe(lnk.dqs_oe));

  always #5 clock = ~clock;

  // ********
  // checking and run control
  // ********
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic hang();
    n_mismatch++;
    $display("wrong value wait expected done seen timeout");
    results();
  endtask : hang

  // ********
  // request port driver
  // ********
  task automatic issue(input drbt_cmd_e c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic l8);
    int i;
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_bl8 <= l8;
    i = 0;
    @(negedge clock);
    while (req_ready !== 1'b1) begin
      if (++i > 400) hang();
      @(negedge clock);
    end
    @(posedge clock);
    req_valid <= 1'b0;
  endtask : issue

  // expected length from the mode and the select bit
  function automatic logic exp_is8(input logic [1:0] mode, input logic l8);
    exp_is8 = (mode == BURST_FIXED8) || ((mode == BURST_OTF) && l8);
  endfunction : exp_is8

  // expected beat pair k of a burst, column wraps in the array
  function automatic logic [31:0] exp_pair(input logic [5:0] col, input int k);
    logic [5:0] lo;
    lo = col + 6'(2 * k);
    exp_pair = {mem[lo + 6'h1], mem[lo]};
  endfunction : exp_pair

  task automatic rd(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic l8);
    int n;
    last8 = exp_is8(burst_mode, l8);
    n = last8 ? BL8_DATA_CK : BC4_DATA_CK;
    for (int k = 0; k < n; k++)
      exp_q.push_back(exp_pair(a[5:0], k));
    exp_beats += n;
    n_rd++;
    issue(CMD_RD, b, a, l8);
  endtask : rd

  task automatic drain();
    int i;
    i = 0;
    while (exp_q.size() != 0) begin
      if (++i > 3000) hang();
      @(posedge clock);
    end
    check("data cycles", 32'(exp_beats), 32'(n_beats));
    check("burst length", 32'(last8), 32'(burst8_seen));
    check("read count", 32'(n_rd), 32'(n_seen));
  endtask : drain

  always @(negedge lnk.ck) begin
    if (lnk.dq_oe === 1'b1) n_beats++;
    if (rd_seen === 1'b1) n_seen++;
  end

  always @(negedge clock) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected return", 32'h0, 32'h1);
      else
        check("read data", exp_q.pop_front(), rd_data);
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    logic [ADDR_W-1:0] a;
    int i;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    i = 0;
    while (lnk.rst_link_n !== 1'b1) begin
      if (++i > 200) hang();
      @(posedge clock);
    end
    for (int w = 0; w < 64; w++) begin
      @(posedge lnk.ck);
      mem[w] = DW_DEF'($random(seed));
      load_en <= 1'b1;
      load_addr <= w[5:0];
      load_data <= mem[w];
    end
    @(posedge lnk.ck);
    load_en <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      @(posedge clock);
      burst_mode <= m[1:0];
      // let the mode setting settle in the link domain
      repeat (3) @(posedge lnk.ck);
      issue(CMD_ACT, 3'h2, 14'h0, 1'b0);
      for (int r = 0; r < 12; r++) begin
        a = ADDR_W'($random(seed));
        // wrap of the column inside the burst
        if (r == 0) a[5:0] = 6'h3f;
        repeat ($unsigned($random(seed)) % 6) @(posedge clock);
        rd(3'h2, a, a[13]);
      end
      issue(CMD_WR, 3'h2, 14'h0, 1'b1);
      issue(CMD_PRE, 3'h2, 14'h0, 1'b0);
      drain();
    end
    check("closed flag", 32'h0, 32'(closed_err));
    // close and reopen a bank at its shortest legal spacings
    issue(CMD_ACT, 3'h6, 14'h0, 1'b0);
    issue(CMD_PRE, 3'h6, 14'h0, 1'b0);
    issue(CMD_ACT, 3'h6, 14'h0, 1'b0);
    issue(CMD_PRE, 3'h6, 14'h0, 1'b0);
    rd(3'h5, 14'h1, 1'b1);
    drain();
    check("closed flag", 32'h1, 32'(closed_err));
    @(posedge lnk.ck);
    err_clr <= 1'b1;
    @(posedge lnk.ck);
    err_clr <= 1'b0;
    @(posedge lnk.ck);
    @(negedge lnk.ck);
    check("closed flag", 32'h0, 32'(closed_err));
    results();
  end
endmodule : dram_read_burst_timing_tb
